/* File: include/ssf_pkg.sv */
// ssf_pkg: constants shared by the slave status flag block.
// assumes one clock domain and an avalon-mm word-addressed slave port.
package ssf_pkg;
   localparam int         ADDR_W         = 2;
   localparam logic [1:0] OFF_STATUS     = 2'h0;
   localparam logic [1:0] OFF_RX_DATA    = 2'h1;
   localparam logic [1:0] OFF_TX_DATA    = 2'h2;
   localparam logic [1:0] OFF_CONTROL    = 2'h3;
   localparam int         BIT_NO_ACK     = 0;
   localparam int         BIT_RX_OVF     = 1;
   localparam int         BIT_RX_IRQ     = 2;
   localparam int         BIT_TX_IRQ     = 3;
   localparam int         BIT_TX_UNF     = 4;
   localparam int         BIT_TX_NFULL   = 5;
   localparam int         BIT_FLUSH      = 0;
   localparam logic [5:0] FLAGS_RESET    = 6'h00;
endpackage : ssf_pkg

/* File: logic/ssf_flags.sv */
// ssf_flags: status flag logic of an i2c slave, with avalon-mm register port.
// assumes event pulses from the slave engine and fifos, one cycle each.
`timescale 1ns/1ps
module ssf_flags #(
   parameter int DATA_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [1:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              ev_read_no_data,
   input  wire logic              ev_rx_overflow,
   input  wire logic              ev_rx_byte,
   input  wire logic              ev_tx_done,
   input  wire logic              ev_tx_underflow,
   input  wire logic              tx_fifo_full,
   input  wire logic [DATA_W-1:0] rx_fifo_data,
   output logic                   rx_fifo_pop,
   output logic                   rx_fifo_flush,
   output logic      [DATA_W-1:0] tx_fifo_data,
   output logic                   tx_fifo_push,
   output logic      [5:0]        flags
);
   logic [5:0]        flags_reg, flags_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic              ack_reg, ack_next;
   logic [DATA_W-1:0] txd_reg, txd_next;
   logic              push_reg, push_next;
   logic              pop_reg, pop_next;
   logic              flush_reg, flush_next;
   logic              acc, rd_stat, wr_stat, rd_rx, wr_tx, wr_ctl;

   // one wait cycle per access: request taken at the edge where waitrequest is low
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   // the access acts only in the cycle where waitrequest is low
   assign acc     = (avs_read | avs_write) & ack_reg;
   assign rd_stat = acc & avs_read  & (avs_address == ssf_pkg::OFF_STATUS);
   assign wr_stat = acc & avs_write & (avs_address == ssf_pkg::OFF_STATUS);
   assign rd_rx   = acc & avs_read  & (avs_address == ssf_pkg::OFF_RX_DATA);
   assign wr_tx   = acc & avs_write & (avs_address == ssf_pkg::OFF_TX_DATA);
   assign wr_ctl  = acc & avs_write & (avs_address == ssf_pkg::OFF_CONTROL);

   always_comb begin
      flags_next = flags_reg;
      if (rd_stat) flags_next[ssf_pkg::BIT_NO_ACK] = 1'b0;
      if (ev_read_no_data) flags_next[ssf_pkg::BIT_NO_ACK] = 1'b1;
      if (rd_stat) flags_next[ssf_pkg::BIT_RX_OVF] = 1'b0;
      if (ev_rx_overflow) flags_next[ssf_pkg::BIT_RX_OVF] = 1'b1;
      if (rd_rx | (wr_ctl & avs_writedata[ssf_pkg::BIT_FLUSH]))
         flags_next[ssf_pkg::BIT_RX_IRQ] = 1'b0;
      if (ev_rx_byte) flags_next[ssf_pkg::BIT_RX_IRQ] = 1'b1;
      if (wr_tx) flags_next[ssf_pkg::BIT_TX_IRQ] = 1'b0;
      if (ev_tx_done) flags_next[ssf_pkg::BIT_TX_IRQ] = 1'b1;
      if (wr_stat) flags_next[ssf_pkg::BIT_TX_UNF] = 1'b0;
      if (ev_tx_underflow) flags_next[ssf_pkg::BIT_TX_UNF] = 1'b1;
      flags_next[ssf_pkg::BIT_TX_NFULL] = ~tx_fifo_full;
   end

   always_comb begin
      ack_next   = (avs_read | avs_write) & ~ack_reg;
      rdata_next = rdata_reg;
      txd_next   = txd_reg;
      push_next  = wr_tx;
      pop_next   = rd_rx;
      flush_next = wr_ctl & avs_writedata[ssf_pkg::BIT_FLUSH];
      if (wr_tx) txd_next = avs_writedata[DATA_W-1:0];
      if (acc & avs_read) begin
         unique case (avs_address)
            ssf_pkg::OFF_STATUS:  rdata_next = {26'h0, flags_reg};
            ssf_pkg::OFF_RX_DATA: rdata_next = {{(32-DATA_W){1'b0}}, rx_fifo_data};
            default:              rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_reg <= ssf_pkg::FLAGS_RESET;
         rdata_reg <= 32'h0;
         ack_reg   <= 1'b0;
         txd_reg   <= '0;
         push_reg  <= 1'b0;
         pop_reg   <= 1'b0;
         flush_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
         txd_reg   <= txd_next;
         push_reg  <= push_next;
         pop_reg   <= pop_next;
         flush_reg <= flush_next;
      end
   end

   // read data is sampled combinationally from current state so it stands at the ack edge
   assign avs_readdata  = (avs_address == ssf_pkg::OFF_STATUS) ? {26'h0, flags_reg} :
                          (avs_address == ssf_pkg::OFF_RX_DATA) ?
                          {{(32-DATA_W){1'b0}}, rx_fifo_data} : rdata_reg & 32'h0;
   assign flags         = flags_reg;
   assign tx_fifo_data  = txd_reg;
   assign tx_fifo_push  = push_reg;
   assign rx_fifo_pop   = pop_reg;
   assign rx_fifo_flush = flush_reg;

   a_noack_set: assert property (@(posedge clk) disable iff (rst)
      ev_read_no_data |=> flags_reg[ssf_pkg::BIT_NO_ACK]) else $error("no-ack not set");
   a_noack_clr: assert property (@(posedge clk) disable iff (rst)
      rd_stat && !ev_read_no_data |=> !flags_reg[ssf_pkg::BIT_NO_ACK])
      else $error("no-ack not cleared");
   a_ovf_clr: assert property (@(posedge clk) disable iff (rst)
      rd_stat && !ev_rx_overflow |=> !flags_reg[ssf_pkg::BIT_RX_OVF])
      else $error("overflow not cleared");
   a_ovf_hold: assert property (@(posedge clk) disable iff (rst)
      ev_rx_overflow ##1 !rd_stat |=> flags_reg[ssf_pkg::BIT_RX_OVF])
      else $error("overflow lost");
   a_rxirq_clr: assert property (@(posedge clk) disable iff (rst)
      rd_rx && !ev_rx_byte |=> !flags_reg[ssf_pkg::BIT_RX_IRQ])
      else $error("rx irq not cleared");
   a_txirq_clr: assert property (@(posedge clk) disable iff (rst)
      wr_tx && !ev_tx_done |=> !flags_reg[ssf_pkg::BIT_TX_IRQ] && tx_fifo_push)
      else $error("tx irq not cleared");
   a_unf_clr: assert property (@(posedge clk) disable iff (rst)
      wr_stat && !ev_tx_underflow |=> !flags_reg[ssf_pkg::BIT_TX_UNF])
      else $error("underflow not cleared");
   a_nfull_track: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> flags_reg[ssf_pkg::BIT_TX_NFULL] == !$past(tx_fifo_full))
      else $error("not-full wrong");
   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      rd_rx && ev_rx_byte |=> flags_reg[ssf_pkg::BIT_RX_IRQ])
      else $error("set lost to clear");

   // bus handshake in two steps: one wait cycle, then the accepting cycle
   sequence s_wait_cycle;
      (avs_read | avs_write) && avs_waitrequest;
   endsequence : s_wait_cycle

   sequence s_accept_cycle;
      (avs_read | avs_write) && !avs_waitrequest;
   endsequence : s_accept_cycle

   a_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
      s_wait_cycle ##1 (avs_read | avs_write) |-> !avs_waitrequest)
      else $error("waitrequest held too long");
   a_bus_rewait: assert property (@(posedge clk) disable iff (rst)
      s_accept_cycle ##1 (avs_read | avs_write) |-> avs_waitrequest)
      else $error("back to back request not held off");
   a_noack_hold: assert property (@(posedge clk) disable iff (rst)
      ev_read_no_data ##1 !rd_stat |=> flags_reg[ssf_pkg::BIT_NO_ACK])
      else $error("no-ack lost");
   a_ovf_set: assert property (@(posedge clk) disable iff (rst)
      ev_rx_overflow |=> flags_reg[ssf_pkg::BIT_RX_OVF])
      else $error("overflow not set");
   a_rxirq_set: assert property (@(posedge clk) disable iff (rst)
      ev_rx_byte |=> flags_reg[ssf_pkg::BIT_RX_IRQ])
      else $error("rx irq not set");
   a_rxirq_flush: assert property (@(posedge clk) disable iff (rst)
      wr_ctl && avs_writedata[ssf_pkg::BIT_FLUSH] && !ev_rx_byte
      |=> !flags_reg[ssf_pkg::BIT_RX_IRQ] && rx_fifo_flush)
      else $error("flush did not clear rx irq");
   a_rx_pop: assert property (@(posedge clk) disable iff (rst)
      rd_rx |=> rx_fifo_pop)
      else $error("rx read did not pop");
   a_txirq_set: assert property (@(posedge clk) disable iff (rst)
      ev_tx_done |=> flags_reg[ssf_pkg::BIT_TX_IRQ])
      else $error("tx irq not set");
   a_unf_set: assert property (@(posedge clk) disable iff (rst)
      ev_tx_underflow |=> flags_reg[ssf_pkg::BIT_TX_UNF])
      else $error("underflow not set");
   a_unf_keep: assert property (@(posedge clk) disable iff (rst)
      flags_reg[ssf_pkg::BIT_TX_UNF] && !wr_stat |=> flags_reg[ssf_pkg::BIT_TX_UNF])
      else $error("underflow cleared without status write");
   a_noack_wins: assert property (@(posedge clk) disable iff (rst)
      rd_stat && ev_read_no_data |=> flags_reg[ssf_pkg::BIT_NO_ACK])
      else $error("no-ack set lost to clear");
endmodule : ssf_flags

/* File: dv/ssf_bus_master_model.sv */
// ssf_bus_master_model: far-side bus master, turns requests into engine events.
// assumes the bench holds each request for one cycle.
`timescale 1ns/1ps
module ssf_bus_master_model (
   input  wire logic       clk,
   input  wire logic [4:0] req,
   output logic      [4:0] ev
);
   // registered so each event is one clean cycle wide
   always_ff @(posedge clk) begin
      ev <= req;
   end
endmodule : ssf_bus_master_model

/* File: dv/ssf_flags_tb_top.sv */
// ssf_flags_tb_top: self-checking bench of the slave status flags.
// assumes one wait cycle per avalon request.
`timescale 1ns/1ps
module ssf_flags_tb_top;
   logic        clk = 0, rst = 1, rd_s = 0, wr_s = 0, wt, full = 0, push;
   logic [1:0]  adr = 2'h0;
   logic [4:0]  req = 5'h00, ev;
   logic [7:0]  rxd = 8'h00, txq;
   logic [31:0] wd = 32'h0, rdat, seed, txd, q[$], x;
   logic        pop, fl, pe = 0, fe = 0;
   logic [5:0]  fo;
   int          errors = 0, n_tests = 0, cyc = 0;
   always #20 clk = ~clk;
   ssf_bus_master_model i_bm (.clk(clk), .req(req), .ev(ev));
   ssf_flags i_dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
      .ev_read_no_data(ev[0]), .ev_rx_overflow(ev[1]), .ev_rx_byte(ev[2]),
      .ev_tx_done(ev[3]), .ev_tx_underflow(ev[4]), .tx_fifo_full(full),
      .rx_fifo_data(rxd), .rx_fifo_pop(pop), .rx_fifo_flush(fl), .tx_fifo_data(txq),
      .tx_fifo_push(push), .flags(fo));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      n_tests++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic complete_run();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   // w=0 read with expected d, w=1 write d; e fires events in the accept cycle
   task automatic bus(input int w, input int a, input logic [31:0] d, input int e);
      if (w == 0) q.push_back(d);
      @(posedge clk);
      adr <= 2'(a);
      wd <= d;
      rd_s <= (w == 0);
      wr_s <= (w != 0);
      req <= 5'(e);
      do begin
         @(posedge clk);
         req <= 5'h00;
      end while (wt !== 1'b0);
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask : bus
   task automatic pulse(input logic [4:0] e);
      @(posedge clk);
      req <= e;
      @(posedge clk);
      req <= 5'h00;
   endtask : pulse
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         complete_run();
      end
      if (rd_s === 1'b1 && wt === 1'b0) begin
         x = q.pop_front();
         chk("avs_readdata", x, rdat);
         if (adr == 2'h0) chk("flags", x, {26'h0, fo});
      end
      if (rst === 1'b0) begin
         chk("rx_fifo_pop", {31'h0, pe}, {31'h0, pop});
         chk("rx_fifo_flush", {31'h0, fe}, {31'h0, fl});
      end
      pe <= rd_s === 1'b1 && wt === 1'b0 && adr == 2'h1;
      fe <= wr_s === 1'b1 && wt === 1'b0 && adr == 2'h3 && wd[0];
      if (push === 1'b1) chk("tx_fifo_data", {24'h0, txd[7:0]}, {24'h0, txq});
   end
   initial begin
      seed = 32'heac7c4e6;
      txd = $random(seed);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rxd <= 8'($random(seed));
      bus(0, 0, 32'h20, 0);
      pulse(5'h03);
      bus(0, 0, 32'h23, 0);
      bus(0, 0, 32'h20, 0);
      bus(0, 0, 32'h20, 1);
      bus(0, 0, 32'h21, 0);
      $display("done status clear");
      pulse(5'h04);
      bus(0, 0, 32'h24, 0);
      bus(0, 1, {24'h0, rxd}, 0);
      bus(0, 0, 32'h20, 0);
      pulse(5'h04);
      bus(1, 3, 32'h1, 0);
      bus(0, 0, 32'h20, 0);
      $display("done rx");
      pulse(5'h18);
      bus(0, 0, 32'h38, 0);
      bus(1, 2, txd, 0);
      bus(0, 0, 32'h30, 0);
      bus(1, 0, 32'h0, 0);
      bus(0, 0, 32'h20, 0);
      $display("done tx");
      full <= 1'b1;
      bus(0, 0, 32'h0, 0);
      full <= 1'b0;
      bus(0, 0, 32'h20, 0);
      $display("done not full");
      complete_run();
   end
endmodule : ssf_flags_tb_top
